/* File: design/gas_link_if.sv */
interface gas_link_if;
	logic scl;
	logic sda;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic uart_h2d;
	logic uart_d2h;

	// Open-drain wires with pull-ups
	assign scl = !(host_scl_oe && !host_scl_o);
	assign sda = !(host_sda_oe && !host_sda_o) && !(dev_sda_oe && !dev_sda_o);

	modport device(input scl, input sda, input uart_h2d,
		output dev_sda_o, output dev_sda_oe, output uart_d2h);
	modport host(input scl, input sda, input uart_d2h,
		output host_scl_o, output host_scl_oe, output host_sda_o,
		output host_sda_oe, output uart_h2d);
endinterface

/* File: design/gas_sensor_device.sv */
`include "gas_sensor_map.svh"

module gas_sensor_device import gas_sensor_pkg::*; #(
	parameter int MS_CYCLES = `MS_CYCLES,
	parameter int UPDATE_MS = `UPDATE_MS,
	parameter int CAL_MS = `CAL_MS,
	parameter int CAL_REPEAT_MS = `CAL_REPEAT_MS,
	parameter int RANGE_PPM = `RANGE_PPM,
	parameter int BIT_CYCLES = `BIT_CYCLES
)
(
	input wire logic clk,
	input wire logic reset_n,
	gas_link_if.device link,
	input wire logic [15:0] conc_ppm,
	input wire logic cal_pin,
	output logic alarm,
	output logic pwm_out,
	output logic timed_manual_calibration,
	output logic auto_baseline_calibration
);
	logic [31:0] ms_cnt_q, upd_cnt_q, pms_q, hi_ms_q, cal_ms_q;
	logic ms_tick, upd_tick;
	logic [15:0] conc_q;
	logic [23:0] bcd;
	logic [9:0] tx_sh_q;
	logic [31:0] baud_q;
	logic [3:0] txn_q, rep_idx_q;
	logic tx_busy_q;
	logic [7:0] rx_byte;
	logic rx_valid;
	logic cal_pin_q, stop_pend_q, cal_go, cal_end;
	target_state_t tgt_q;
	logic scl_q, sda_q, scl_rise, scl_fall, i2c_start, i2c_stop;
	logic [3:0] bit_q;
	logic [7:0] sh_q, tx_q, next_byte, wr_byte_q;
	logic [2:0] idx_q;
	logic rw_q, hack_q, wr_valid_q, more_rd;

	function automatic logic [23:0] to_bcd(input logic [15:0] v);
		logic [39:0] s;
		s = {24'h0, v};
		for (int i = 0; i < 16; i++)
		begin
			for (int j = 0; j < 6; j++)
				if (s[16 + 4 * j +: 4] > 4'h4)
					s[16 + 4 * j +: 4] = s[16 + 4 * j +: 4] + 4'h3;
			s = s << 1;
		end
		return s[39:16];
	endfunction

	function automatic logic [7:0] rep_byte(input logic [3:0] i,
		input logic [23:0] b);
		int k;
		k = 5 - int'(i);
		case (i)
		4'h6: return `ASCII_SPACE;
		4'h7, 4'h8: return `ASCII_P;
		4'h9: return `ASCII_M;
		4'ha: return `ASCII_CR;
		4'hb: return `ASCII_LF;
		default:
			if (k > 0 && (b >> (4 * k)) == 24'h0)
				return `ASCII_SPACE;
			else
				return `ASCII_ZERO | {4'h0, b[4 * k +: 4]};
		endcase
	endfunction

	function automatic logic [31:0] high_ms(input logic [15:0] c);
		logic [31:0] v;
		v = (c > RANGE_PPM) ? RANGE_PPM : {16'h0, c};
		return `PWM_START_MS + (`PWM_SPAN_MS * v) / RANGE_PPM;
	endfunction

	assign ms_tick = (ms_cnt_q == MS_CYCLES - 1);
	assign upd_tick = ms_tick && (upd_cnt_q == UPDATE_MS - 1);
	assign bcd = to_bcd(conc_q);

	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			ms_cnt_q <= 32'h0;
			upd_cnt_q <= 32'h0;
			conc_q <= 16'h0;
		end
		else
		begin
			ms_cnt_q <= ms_tick ? 32'h0 : ms_cnt_q + 32'h1;
			if (ms_tick)
				upd_cnt_q <= upd_tick ? 32'h0 : upd_cnt_q + 32'h1;
			if (upd_tick)
				conc_q <= conc_ppm;
		end

	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			alarm <= 1'b0;
		else if (conc_q >= `ALARM_ON_PPM)
			alarm <= 1'b1;
		else if (conc_q <= `ALARM_OFF_PPM)
			alarm <= 1'b0;

	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			pms_q <= 32'h0;
			hi_ms_q <= `PWM_START_MS;
			pwm_out <= 1'b0;
		end
		else
		begin
			if (ms_tick)
			begin
				pms_q <= (pms_q == `PWM_PERIOD_MS - 1) ? 32'h0 : pms_q + 32'h1;
				if (pms_q == `PWM_PERIOD_MS - 1)
					hi_ms_q <= high_ms(conc_q);
			end
			pwm_out <= (pms_q < hi_ms_q);
		end

	// Report serialiser, one 12-frame report per update
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			tx_sh_q <= 10'h3ff;
			baud_q <= 32'h0;
			txn_q <= 4'h0;
			rep_idx_q <= 4'h0;
			tx_busy_q <= 1'b0;
		end
		else if (!tx_busy_q)
		begin
			if (upd_tick)
			begin
				tx_busy_q <= 1'b1;
				rep_idx_q <= 4'h0;
				txn_q <= 4'h0;
				baud_q <= 32'h0;
				tx_sh_q <= {1'b1, rep_byte(4'h0, bcd), 1'b0};
			end
		end
		else if (baud_q == BIT_CYCLES - 1)
		begin
			baud_q <= 32'h0;
			if (txn_q == 4'h9)
			begin
				txn_q <= 4'h0;
				rep_idx_q <= rep_idx_q + 4'h1;
				if (rep_idx_q == `REPORT_LEN - 1)
				begin
					tx_busy_q <= 1'b0;
					tx_sh_q <= 10'h3ff;
				end
				else
					tx_sh_q <= {1'b1, rep_byte(rep_idx_q + 4'h1, bcd), 1'b0};
			end
			else
			begin
				txn_q <= txn_q + 4'h1;
				tx_sh_q <= {1'b1, tx_sh_q[9:1]};
			end
		end
		else
			baud_q <= baud_q + 32'h1;

	assign link.uart_d2h = tx_sh_q[0];

	serial_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
		.clk(clk),
		.reset_n(reset_n),
		.rxd(link.uart_h2d),
		.rx_data(rx_byte),
		.rx_valid(rx_valid)
	);

	assign cal_go = (rx_valid && rx_byte == `CMD_CAL_START)
		|| (wr_valid_q && wr_byte_q == `CMD_CAL_START)
		|| (cal_pin && !cal_pin_q);
	assign cal_end = (rx_valid && rx_byte == `CMD_CAL_STOP)
		|| (wr_valid_q && wr_byte_q == `CMD_CAL_STOP)
		|| (!cal_pin && cal_pin_q);

	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			cal_pin_q <= 1'b0;
			cal_ms_q <= 32'h0;
			stop_pend_q <= 1'b0;
			timed_manual_calibration <= 1'b0;
			auto_baseline_calibration <= 1'b1;
		end
		else
		begin
			cal_pin_q <= cal_pin;
			if (!timed_manual_calibration)
			begin
				if (cal_go)
				begin
					timed_manual_calibration <= 1'b1;
					auto_baseline_calibration <= 1'b0;
					cal_ms_q <= 32'h0;
					stop_pend_q <= 1'b0;
				end
			end
			else if ((stop_pend_q || cal_end) && cal_ms_q >= CAL_MS)
			begin
				timed_manual_calibration <= 1'b0;
				auto_baseline_calibration <= 1'b1;
			end
			else
			begin
				if (cal_end)
					stop_pend_q <= 1'b1;
				// Left running too long: the cycle starts over
				if (ms_tick)
					cal_ms_q <= (cal_ms_q == CAL_REPEAT_MS - 1) ? 32'h0
						: cal_ms_q + 32'h1;
			end
		end

	// I2C target
	assign scl_rise = link.scl && !scl_q;
	assign scl_fall = !link.scl && scl_q;
	assign i2c_start = link.scl && scl_q && sda_q && !link.sda;
	assign i2c_stop = link.scl && scl_q && !sda_q && link.sda;
	assign link.dev_sda_o = 1'b0;
	// Last byte acked: let go of the line so a STOP can follow
	assign more_rd = hack_q && (idx_q != 3'(`READ_LEN));

	always_comb
		case (idx_q)
		3'h0: next_byte = {6'h00, alarm, timed_manual_calibration};
		3'h1: next_byte = conc_q[15:8];
		3'h2: next_byte = conc_q[7:0];
		default: next_byte = 8'h00;
		endcase

	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			tgt_q <= TGT_IDLE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			idx_q <= 3'h0;
			rw_q <= 1'b0;
			hack_q <= 1'b0;
			wr_valid_q <= 1'b0;
			wr_byte_q <= 8'h00;
			link.dev_sda_oe <= 1'b0;
		end
		else
		begin
			scl_q <= link.scl;
			sda_q <= link.sda;
			wr_valid_q <= 1'b0;
			if (i2c_stop)
			begin
				tgt_q <= TGT_IDLE;
				link.dev_sda_oe <= 1'b0;
			end
			else if (i2c_start)
			begin
				tgt_q <= TGT_ADDR;
				bit_q <= 4'h0;
				link.dev_sda_oe <= 1'b0;
			end
			else
				case (tgt_q)
				TGT_ADDR, TGT_WR:
				begin
					if (scl_rise)
					begin
						sh_q <= {sh_q[6:0], link.sda};
						bit_q <= bit_q + 4'h1;
					end
					if (scl_fall && bit_q == 4'h8)
					begin
						bit_q <= 4'h0;
						if (tgt_q == TGT_WR)
						begin
							wr_valid_q <= 1'b1;
							wr_byte_q <= sh_q;
							tgt_q <= TGT_ACK;
							link.dev_sda_oe <= 1'b1;
						end
						else if (sh_q[7:1] == `I2C_ADDR)
						begin
							rw_q <= sh_q[0];
							idx_q <= 3'h0;
							tgt_q <= TGT_ACK;
							link.dev_sda_oe <= 1'b1;
						end
						else
							tgt_q <= TGT_IDLE;
					end
				end
				TGT_ACK:
					if (scl_fall)
					begin
						tgt_q <= rw_q ? TGT_RD : TGT_WR;
						tx_q <= next_byte;
						link.dev_sda_oe <= rw_q && !next_byte[7];
					end
				TGT_RD:
					if (scl_fall)
					begin
						if (bit_q == 4'h7)
						begin
							bit_q <= 4'h0;
							tgt_q <= TGT_HACK;
							link.dev_sda_oe <= 1'b0;
						end
						else
						begin
							bit_q <= bit_q + 4'h1;
							tx_q <= {tx_q[6:0], 1'b0};
							link.dev_sda_oe <= !tx_q[6];
						end
					end
				TGT_HACK:
				begin
					if (scl_rise)
					begin
						hack_q <= !link.sda;
						if (!link.sda)
							idx_q <= idx_q + 3'h1;
					end
					if (scl_fall)
					begin
						tgt_q <= more_rd ? TGT_RD : TGT_IDLE;
						tx_q <= next_byte;
						link.dev_sda_oe <= more_rd && !next_byte[7];
					end
				end
				default:
					link.dev_sda_oe <= 1'b0;
				endcase
		end
endmodule

/* File: design/gas_sensor_host.sv */
`include "gas_sensor_map.svh"

module gas_sensor_host import gas_sensor_pkg::*; #(
	parameter int GAP_CYCLES = `MS_CYCLES,
	parameter int QTR_CYCLES = `I2C_QTR_CYCLES,
	parameter int BIT_CYCLES = `BIT_CYCLES
)
(
	input wire logic clk,
	input wire logic reset_n,
	gas_link_if.host link,
	input wire logic go,
	input wire logic [7:0] cmd,
	input wire logic tx_go,
	input wire logic [7:0] tx_data,
	output logic busy,
	output logic done,
	output logic nack,
	output logic [7:0] cfg_byte,
	output logic [15:0] conc_read,
	output logic [7:0] rep_data,
	output logic rep_valid,
	output logic tx_busy
);
	localparam logic [3:0] STEP_RD_FIRST = 4'h6;
	localparam logic [3:0] STEP_RD_LAST = 4'hc;
	localparam logic [3:0] STEP_END = 4'he;
	ctl_state_t st_q;
	logic [31:0] qc_q, gap_q, ucnt_q;
	logic [1:0] ph_q;
	logic [3:0] bit_q, step_q, un_q;
	logic [7:0] sh_q, rsh_q, cmd_q;
	logic [9:0] utx_q;
	logic ack_q, qtick, reading;

	assign qtick = (qc_q == QTR_CYCLES - 1);
	assign reading = step_q >= STEP_RD_FIRST && step_q <= STEP_RD_LAST;
	assign link.host_scl_o = 1'b0;
	assign link.host_sda_o = 1'b0;
	assign link.uart_h2d = utx_q[0];

	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			st_q <= CTL_IDLE;
			qc_q <= 32'h0;
			gap_q <= 32'h0;
			ph_q <= 2'h0;
			bit_q <= 4'h0;
			step_q <= 4'h0;
			sh_q <= 8'h00;
			rsh_q <= 8'h00;
			cmd_q <= 8'h00;
			ack_q <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			nack <= 1'b0;
			cfg_byte <= 8'h00;
			conc_read <= 16'h0;
			link.host_scl_oe <= 1'b0;
			link.host_sda_oe <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			qc_q <= qtick ? 32'h0 : qc_q + 32'h1;
			case (st_q)
			CTL_IDLE:
				if (go)
				begin
					busy <= 1'b1;
					nack <= 1'b0;
					cmd_q <= cmd;
					step_q <= 4'h0;
					st_q <= CTL_NEXT;
				end
			CTL_NEXT:
			begin
				ph_q <= 2'h0;
				bit_q <= 4'h0;
				gap_q <= 32'h0;
				case (step_q)
				4'h0, 4'h4: st_q <= CTL_START;
				4'h1: sh_q <= {`I2C_ADDR, 1'b0};
				4'h2: sh_q <= cmd_q;
				4'h5: sh_q <= {`I2C_ADDR, 1'b1};
				4'h3, 4'hd: st_q <= CTL_STOP;
				default: ;
				endcase
				if (step_q == 4'h1 || step_q == 4'h2 || step_q == 4'h5)
					st_q <= CTL_BIT;
				else if (reading)
					st_q <= CTL_GAP;
				else if (step_q == STEP_END)
				begin
					st_q <= CTL_IDLE;
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
			CTL_GAP:
				if (gap_q == GAP_CYCLES - 1)
					st_q <= CTL_BIT;
				else
					gap_q <= gap_q + 32'h1;
			CTL_START:
				if (qtick)
				begin
					ph_q <= ph_q + 2'h1;
					case (ph_q)
					2'h0:
					begin
						link.host_sda_oe <= 1'b0;
						link.host_scl_oe <= 1'b0;
					end
					2'h1: link.host_sda_oe <= 1'b1;
					2'h2: link.host_scl_oe <= 1'b1;
					default:
					begin
						step_q <= step_q + 4'h1;
						st_q <= CTL_NEXT;
					end
					endcase
				end
			CTL_STOP:
				if (qtick)
				begin
					ph_q <= ph_q + 2'h1;
					case (ph_q)
					2'h0: link.host_sda_oe <= 1'b1;
					2'h1: link.host_scl_oe <= 1'b0;
					2'h2: link.host_sda_oe <= 1'b0;
					default:
					begin
						st_q <= CTL_NEXT;
						if (step_q == 4'h3 && cmd_q != `CMD_READ)
							step_q <= STEP_END;
						else
							step_q <= step_q + 4'h1;
					end
					endcase
				end
			CTL_BIT:
				if (qtick)
				begin
					ph_q <= ph_q + 2'h1;
					case (ph_q)
					2'h0:
						if (bit_q == 4'h8)
							link.host_sda_oe <= reading;
						else
							link.host_sda_oe <= !reading && !sh_q[7];
					2'h1: link.host_scl_oe <= 1'b0;
					2'h2:
						if (bit_q == 4'h8)
							ack_q <= !link.sda;
						else
							rsh_q <= {rsh_q[6:0], link.sda};
					default:
					begin
						link.host_scl_oe <= 1'b1;
						sh_q <= {sh_q[6:0], 1'b0};
						bit_q <= bit_q + 4'h1;
						if (bit_q == 4'h8)
						begin
							st_q <= CTL_NEXT;
							step_q <= step_q + 4'h1;
							if (!reading && !ack_q)
							begin
								nack <= 1'b1;
								step_q <= 4'hd;
							end
							if (step_q == STEP_RD_FIRST)
								cfg_byte <= rsh_q;
							if (step_q == STEP_RD_FIRST + 4'h1)
								conc_read[15:8] <= rsh_q;
							if (step_q == STEP_RD_FIRST + 4'h2)
								conc_read[7:0] <= rsh_q;
						end
					end
					endcase
				end
			default:
				st_q <= CTL_IDLE;
			endcase
		end

	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			utx_q <= 10'h3ff;
			ucnt_q <= 32'h0;
			un_q <= 4'h0;
			tx_busy <= 1'b0;
		end
		else if (!tx_busy)
		begin
			if (tx_go)
			begin
				tx_busy <= 1'b1;
				utx_q <= {1'b1, tx_data, 1'b0};
				ucnt_q <= 32'h0;
				un_q <= 4'h0;
			end
		end
		else if (ucnt_q == BIT_CYCLES - 1)
		begin
			ucnt_q <= 32'h0;
			utx_q <= {1'b1, utx_q[9:1]};
			un_q <= un_q + 4'h1;
			if (un_q == 4'h9)
				tx_busy <= 1'b0;
		end
		else
			ucnt_q <= ucnt_q + 32'h1;

	serial_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
		.clk(clk),
		.reset_n(reset_n),
		.rxd(link.uart_d2h),
		.rx_data(rep_data),
		.rx_valid(rep_valid)
	);
endmodule

/* File: design/gas_sensor_map.svh */
`ifndef GAS_SENSOR_MAP_SVH
`define GAS_SENSOR_MAP_SVH

`define CLK_HZ 50000000
`define BAUD_RATE 38400
`define BIT_CYCLES (`CLK_HZ / `BAUD_RATE)
`define MS_PER_S 1000
`define MS_PER_MIN 60000
`define MS_CYCLES (`CLK_HZ / `MS_PER_S)

`define UPDATE_S 5
`define UPDATE_MS (`UPDATE_S * `MS_PER_S)
`define CAL_MIN_MINUTES 10
`define CAL_REPEAT_MINUTES 18
`define CAL_MS (`CAL_MIN_MINUTES * `MS_PER_MIN)
`define CAL_REPEAT_MS (`CAL_REPEAT_MINUTES * `MS_PER_MIN)

`define PWM_START_MS 2
`define PWM_SPAN_MS 1000
`define PWM_PERIOD_MS 2000
`define RANGE_PPM 2000
`define ALARM_ON_PPM 16'h04b0
`define ALARM_OFF_PPM 16'h0320

`define I2C_ADDR 7'h31
`define I2C_HZ 100000
`define I2C_QTR_CYCLES (`CLK_HZ / (4 * `I2C_HZ))
`define CMD_READ 8'h52
`define CMD_CAL_START 8'h43
`define CMD_CAL_STOP 8'h53
`define READ_LEN 7
`define CFG_MANUAL_BIT 0
`define CFG_ALARM_BIT 1

`define ASCII_SPACE 8'h20
`define ASCII_ZERO 8'h30
`define ASCII_P 8'h70
`define ASCII_M 8'h6d
`define ASCII_CR 8'h0d
`define ASCII_LF 8'h0a
`define REPORT_LEN 12

`endif

/* File: design/gas_sensor_pkg.sv */
package gas_sensor_pkg;

	typedef enum logic [5:0] {
		TGT_IDLE = 6'h01,
		TGT_ADDR = 6'h02,
		TGT_WR = 6'h04,
		TGT_ACK = 6'h08,
		TGT_RD = 6'h10,
		TGT_HACK = 6'h20
	} target_state_t;

	typedef enum logic [5:0] {
		CTL_IDLE = 6'h01,
		CTL_NEXT = 6'h02,
		CTL_START = 6'h04,
		CTL_BIT = 6'h08,
		CTL_STOP = 6'h10,
		CTL_GAP = 6'h20
	} ctl_state_t;

endpackage

/* File: design/serial_rx.sv */
`include "gas_sensor_map.svh"

module serial_rx #(
	parameter int BIT_CYCLES = `BIT_CYCLES
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic rxd,
	output logic [7:0] rx_data,
	output logic rx_valid
);
	logic busy_q;
	logic [31:0] cnt_q;
	logic [3:0] n_q;
	logic [7:0] sh_q;

	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			busy_q <= 1'b0;
			cnt_q <= 32'h0;
			n_q <= 4'h0;
			sh_q <= 8'h00;
			rx_data <= 8'h00;
			rx_valid <= 1'b0;
		end
		else
		begin
			rx_valid <= 1'b0;
			if (!busy_q)
			begin
				if (!rxd)
				begin
					busy_q <= 1'b1;
					cnt_q <= BIT_CYCLES / 2;
					n_q <= 4'h0;
				end
			end
			else if (cnt_q == 32'h0)
			begin
				cnt_q <= BIT_CYCLES - 1;
				n_q <= n_q + 4'h1;
				// False start, or 8N1 data LSB first, then stop check
				if (n_q == 4'h0 && rxd)
					busy_q <= 1'b0;
				else if (n_q == 4'h9)
				begin
					busy_q <= 1'b0;
					rx_valid <= rxd;
					rx_data <= sh_q;
				end
				else if (n_q != 4'h0)
					sh_q <= {rxd, sh_q[7:1]};
			end
			else
				cnt_q <= cnt_q - 32'h1;
		end
endmodule

/* File: tb/gas_link_sva.sv */
module gas_link_sva #(
	parameter int BIT_CYCLES = 16
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic host_scl_oe,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic uart_h2d,
	input wire logic uart_d2h
);
	localparam int FRAME = 10 * BIT_CYCLES;
	localparam int MID = BIT_CYCLES / 2;
	localparam int STOP_MID = 9 * BIT_CYCLES + MID;
	logic [1:0] line;
	logic [1:0] prev_q;
	int cnt_q [2];

	assign line = {uart_h2d, uart_d2h};

	// Cycles since the start bit of a serial character, 0 when idle
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			prev_q <= 2'h3;
			cnt_q <= '{0, 0};
		end
		else
		begin
			prev_q <= line;
			for (int i = 0; i < 2; i++)
			begin
				if (cnt_q[i] != 0)
					cnt_q[i] <= (cnt_q[i] == FRAME - 1) ? 0 : cnt_q[i] + 1;
				else if (prev_q[i] && !line[i])
					cnt_q[i] <= 1;
			end
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	a_d2h_start_bit: assert property (cnt_q[0] == MID |-> !uart_d2h)
		else $error("device start bit too short");
	a_d2h_stop_bit: assert property (cnt_q[0] == STOP_MID |-> uart_d2h)
		else $error("device stop bit missing");
	a_h2d_start_bit: assert property (cnt_q[1] == MID |-> !uart_h2d)
		else $error("host start bit too short");
	a_h2d_stop_bit: assert property (cnt_q[1] == STOP_MID |-> uart_h2d)
		else $error("host stop bit missing");
	a_lines_idle_release: assert property ($rose(reset_n) |->
		scl && sda && uart_d2h && uart_h2d)
		else $error("lines not idle after reset");
	a_start_from_host: assert property ($fell(sda) && scl && $past(scl)
		|-> host_sda_oe)
		else $error("start condition not made by host");
	a_stop_from_host: assert property ($rose(sda) && scl && $past(scl)
		|-> $past(host_sda_oe))
		else $error("stop condition not made by host");
	a_dev_drive_low: assert property ($rose(dev_sda_oe) |-> !scl)
		else $error("device took data line while clock high");
	a_dev_release_masked: assert property ($fell(dev_sda_oe) && scl
		|-> host_sda_oe)
		else $error("device released data line while clock high");

	c_dev_frame: cover property (cnt_q[0] == STOP_MID);
	c_host_frame: cover property (cnt_q[1] == STOP_MID);
	c_start: cover property ($fell(sda) && scl);
	c_dev_ack: cover property ($rose(dev_sda_oe));
endmodule

/* File: tb/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int MS = 2;
	localparam int BIT = 16;
	logic clk, reset_n, cal_pin, go, tx_go, alarm, pwm_out, manual, auto_cal;
	logic busy, done, nack, rep_valid, tx_busy;
	logic [15:0] conc_ppm, conc_read;
	logic [7:0] cmd, tx_data, cfg_byte, rep_data;
	int error_cnt = 0;
	int cmp_count = 0;
	int n, hi, lo;
	time t_rise;
	int vals [5] = '{1255, 800, 1000, 1200, 0};
	logic alarms [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

	gas_link_if link();
	gas_sensor_device #(.MS_CYCLES(MS), .UPDATE_MS(1000), .CAL_MS(1000),
		.CAL_REPEAT_MS(1800), .BIT_CYCLES(BIT))
		u_gas_sensor_device (.clk(clk), .reset_n(reset_n), .link(link),
		.conc_ppm(conc_ppm), .cal_pin(cal_pin), .alarm(alarm),
		.pwm_out(pwm_out), .timed_manual_calibration(manual),
		.auto_baseline_calibration(auto_cal));
	gas_sensor_host #(.GAP_CYCLES(50), .QTR_CYCLES(8), .BIT_CYCLES(BIT))
		u_gas_sensor_host (.clk(clk), .reset_n(reset_n), .link(link),
		.go(go), .cmd(cmd), .tx_go(tx_go), .tx_data(tx_data), .busy(busy),
		.done(done), .nack(nack), .cfg_byte(cfg_byte),
		.conc_read(conc_read), .rep_data(rep_data), .rep_valid(rep_valid),
		.tx_busy(tx_busy));
	gas_link_sva #(.BIT_CYCLES(BIT)) u_gas_link_sva (.clk(clk),
		.reset_n(reset_n), .scl(link.scl), .sda(link.sda),
		.host_scl_oe(link.host_scl_oe), .host_sda_oe(link.host_sda_oe),
		.dev_sda_oe(link.dev_sda_oe), .uart_h2d(link.uart_h2d),
		.uart_d2h(link.uart_d2h));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Expected report byte: leading zero digits become spaces
	function automatic logic [7:0] frame_byte(input int v, input int i);
		int p;
		p = 10 ** (5 - i);
		case (i)
			6: return 8'h20;
			7, 8: return 8'h70;
			9: return 8'h6d;
			10: return 8'h0d;
			11: return 8'h0a;
			default: return (v < p && i < 5) ? 8'h20 : 8'h30 + (v / p) % 10;
		endcase
	endfunction

	function automatic logic pick(input int s);
		case (s)
			0: return done;
			1: return tx_busy;
			2: return manual;
			default: return pwm_out;
		endcase
	endfunction

	task automatic wait_for(input int s, input logic v, output int k);
		k = 0;
		while (pick(s) !== v && k < 30000)
		begin
			@(negedge clk);
			k++;
		end
	endtask

	task automatic wait_byte(output logic [7:0] b);
		int k;
		k = 0;
		do
		begin
			@(negedge clk);
			k++;
		end
		while (rep_valid !== 1'b1 && k < 5000);
		b = rep_data;
	endtask

	task automatic get_report(input int v);
		logic [7:0] b;
		b = 8'h00;
		while (b !== 8'h0a)
			wait_byte(b);
		for (int i = 0; i < 12; i++)
		begin
			wait_byte(b);
			check(b, frame_byte(v, i));
		end
	endtask

	task automatic i2c_op(input logic [7:0] c);
		int k;
		@(negedge clk);
		cmd = c;
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
		wait_for(0, 1'b1, k);
		check(done, 1'b1);
		check(busy, 1'b0);
		check(nack, 1'b0);
	endtask

	task automatic uart_send(input logic [7:0] d);
		int k;
		@(negedge clk);
		tx_data = d;
		tx_go = 1'b1;
		@(negedge clk);
		tx_go = 1'b0;
		wait_for(1, 1'b0, k);
		repeat (4) @(negedge clk);
	endtask

	always @(posedge manual)
		t_rise = $time;

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial
	begin
		repeat (95000) @(posedge clk);
		error_cnt++;
		$display("Error at %0t: watchdog expired", $time);
		report_and_stop();
	end

	initial
	begin
		reset_n = 1'b0;
		conc_ppm = 16'h0000;
		cal_pin = 1'b0;
		go = 1'b0;
		tx_go = 1'b0;
		cmd = 8'h00;
		tx_data = 8'h00;
		repeat (20) @(negedge clk);
		reset_n = 1'b1;
		check(auto_cal, 1'b1);
		for (int i = 0; i < 5; i++)
		begin
			conc_ppm = vals[i];
			get_report(vals[i]);
			check(alarm, alarms[i]);
			i2c_op(8'h52);
			check(conc_read, vals[i]);
			check(cfg_byte, {6'h00, alarms[i], 1'b0});
		end
		$display("Test reports and reads done");
		for (int j = 0; j < 2; j++)
		begin
			conc_ppm = (j == 0) ? 16'd400 : 16'd2500;
			get_report(conc_ppm);
			wait_for(3, 1'b0, n);
			wait_for(3, 1'b1, n);
			wait_for(3, 1'b0, hi);
			wait_for(3, 1'b1, lo);
			check(hi, (j == 0) ? MS * 202 : MS * 1002);
			check(hi + lo, MS * 2000);
		end
		$display("Test pulse output done");
		for (int s = 0; s < 3; s++)
		begin
			@(negedge clk);
			if (s == 0)
				cal_pin = 1'b1;
			else if (s == 1)
				uart_send(8'h43);
			else
				i2c_op(8'h43);
			wait_for(2, 1'b1, n);
			check(auto_cal, 1'b0);
			if (s == 0)
			begin
				repeat (4000) @(negedge clk);
				check(manual, 1'b1);
				cal_pin = 1'b0;
			end
			else if (s == 1)
				uart_send(8'h53);
			else
				i2c_op(8'h53);
			wait_for(2, 1'b0, n);
			n = ($time - t_rise) / 20;
			if (s != 0)
				check(n >= MS * 1000 && n <= MS * 1000 + 10, 1'b1);
			check(auto_cal, 1'b1);
		end
		$display("Test calibration done");
		report_and_stop();
	end
endmodule
